/* hw/converter_loop.v */
// Loopback switch at the converter boundary.
// Assumes converter codes are synchronous to the core clock.
`timescale 1ns/100ps
`include "phy_bmc_consts.vh"
module converter_loop (
	input  wire               ref_clk,
	input  wire               arst_n,
	input  wire               loop_en,
	input  wire [`CONV_W-1:0] tx_code,
	input  wire [`CONV_W-1:0] adc_code,
	output reg  [`CONV_W-1:0] dac_code_reg,
	output reg  [`CONV_W-1:0] rx_code_reg
);
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			dac_code_reg <= `CONV_IDLE;
			rx_code_reg  <= `CONV_IDLE;
		end else if (loop_en) begin
			// Line drivers see idle so nothing leaks onto the cable
			dac_code_reg <= `CONV_IDLE; // [R9]
			rx_code_reg  <= tx_code; // [R9]
		end else begin
			dac_code_reg <= tx_code;
			rx_code_reg  <= adc_code;
		end
	end
endmodule

/* hw/phy_basic_mode_control_bits.v */
// Basic mode control register bank with status latches and soft reset.
// Assumes bus strobes are one cycle wide and synchronous to ref_clk;
// strap pins are already resolved by their pad pull resistors.
`timescale 1ns/100ps
`include "phy_bmc_consts.vh"
module phy_basic_mode_control_bits #(
	parameter [`SRESET_CNT_W-1:0] SRESET_CYCLES = `SRESET_CYCLES
) (
	input  wire               ref_clk,
	input  wire               arst_n,
	input  wire [`ADDR_W-1:0] addr,
	input  wire [`DATA_W-1:0] wdata,
	input  wire               wr_stb,
	input  wire               rd_stb,
	output reg  [`DATA_W-1:0] rdata_reg,
	input  wire               strap_autoneg_enable,
	input  wire               strap_speed_lo,
	input  wire               strap_speed_hi,
	input  wire               strap_full_duplex,
	input  wire               an_started,
	input  wire               forced_mode_entered,
	input  wire               an_complete,
	input  wire [1:0]         an_speed,
	input  wire               an_full_duplex,
	input  wire               link_up,
	input  wire               remote_fault,
	input  wire               jabber,
	input  wire [`CONV_W-1:0] tx_code,
	input  wire [`CONV_W-1:0] adc_code,
	output wire [`CONV_W-1:0] dac_code_reg,
	output wire [`CONV_W-1:0] rx_code_reg,
	output reg                core_reset_reg,
	output reg                loopback_reg,
	output reg  [1:0]         speed_sel_reg,
	output reg                full_duplex_reg,
	output reg                autoneg_enable_reg,
	output reg                restart_an_reg,
	output reg                power_down_reg,
	output reg                isolate_reg,
	output reg                collision_test_reg
);

	// ****************************************************************
	// State encoding
	// ****************************************************************
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_HOLD = 3'b010;
	localparam [2:0] ST_WAIT = 3'b100;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Reserved code leaves the running speed untouched
	function [1:0] pick_speed;
		input [1:0] code;
		input [1:0] prev;
		begin
			if (code == `SPD_RSVD) begin
				pick_speed = prev; // [R12]
			end else begin
				pick_speed = code; // [R12]
			end
		end
	endfunction

	function hit_addr;
		input [`ADDR_W-1:0] a;
		input [`ADDR_W-1:0] target;
		begin
			hit_addr = (a == target);
		end
	endfunction

	// ****************************************************************
	// Declarations
	// ****************************************************************
	reg  [2:0]              state_reg;
	reg  [2:0]              state_next;
	reg  [`SRESET_CNT_W-1:0] cnt_reg;
	reg  [`SRESET_CNT_W-1:0] cnt_next;
	reg                     strap_done_reg;
	reg                     strap_an_reg;
	reg                     strap_spd_lo_reg;
	reg                     strap_spd_hi_reg;
	reg                     strap_dup_reg;
	reg                     speed_lo_reg;
	reg                     speed_hi_reg;
	reg                     duplex_bit_reg;
	reg                     an_bit_reg;
	wire                    bmc_wr;
	wire                    stat_rd;
	wire                    sreset_busy;
	wire                    defaults_load;
	wire                    link_bit;
	wire                    rfault_bit;
	wire                    jabber_bit;
	reg  [`DATA_W-1:0]      bmc_view;
	reg  [`DATA_W-1:0]      stat_view;
	reg  [`DATA_W-1:0]      rd_mux;

	assign bmc_wr  = wr_stb & hit_addr(addr, `BMC_ADDR);
	assign stat_rd = rd_stb & hit_addr(addr, `STAT_ADDR);
	assign sreset_busy = ~state_reg[0];
	// Defaults load from the starting write on, so bits written beside
	// bit 15 never reach the outputs
	assign defaults_load = state_reg[1] |
			(bmc_wr & wdata[`BMC_SRESET_BIT] & state_reg[0]); // [R6]

	// ****************************************************************
	// Soft reset sequencer
	// ****************************************************************
	always @* begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			ST_IDLE: begin
				if (bmc_wr && wdata[`BMC_SRESET_BIT]) begin
					state_next = ST_HOLD; // [R6]
					cnt_next   = SRESET_CYCLES - 1'b1;
				end
			end
			ST_HOLD: begin
				if (cnt_reg == {`SRESET_CNT_W{1'b0}}) begin
					state_next = ST_WAIT; // [R7]
				end else begin
					cnt_next = cnt_reg - 1'b1; // [R7]
				end
			end
			ST_WAIT: begin
				// Core has restarted in its configured mode
				if (an_started || forced_mode_entered) begin
					state_next = ST_IDLE; // [R8] [R3]
				end
			end
			default: begin
				state_next = ST_IDLE;
				cnt_next   = {`SRESET_CNT_W{1'b0}};
			end
		endcase
	end

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg      <= ST_IDLE;
			cnt_reg        <= {`SRESET_CNT_W{1'b0}};
			core_reset_reg <= 1'b0;
		end else begin
			state_reg      <= state_next;
			cnt_reg        <= cnt_next;
			core_reset_reg <= state_next[1];
		end
	end

	// ****************************************************************
	// Strap capture
	// ****************************************************************
	// Pins are caught on the first edge after release, never under
	// the asynchronous reset itself
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_done_reg   <= 1'b0;
			strap_an_reg     <= 1'b0;
			strap_spd_lo_reg <= 1'b0;
			strap_spd_hi_reg <= 1'b0;
			strap_dup_reg    <= 1'b0;
		end else if (!strap_done_reg) begin
			strap_done_reg   <= 1'b1;
			strap_an_reg     <= strap_autoneg_enable; // [R5]
			strap_spd_lo_reg <= strap_speed_lo; // [R5]
			strap_spd_hi_reg <= strap_speed_hi; // [R5]
			strap_dup_reg    <= strap_full_duplex; // [R5]
		end
	end

	// ****************************************************************
	// Control fields
	// ****************************************************************
	// Writes during a soft reset are dropped; the host must poll bit 15
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			loopback_reg       <= 1'b0;
			speed_lo_reg       <= 1'b0;
			speed_hi_reg       <= 1'b0;
			an_bit_reg         <= 1'b0;
			duplex_bit_reg     <= 1'b0;
			power_down_reg     <= 1'b0;
			isolate_reg        <= 1'b0;
			collision_test_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			loopback_reg       <= 1'b0;
			speed_lo_reg       <= strap_speed_lo; // [R5]
			speed_hi_reg       <= strap_speed_hi; // [R5]
			an_bit_reg         <= strap_autoneg_enable; // [R5]
			duplex_bit_reg     <= strap_full_duplex; // [R5]
			power_down_reg     <= 1'b0;
			isolate_reg        <= 1'b0;
			collision_test_reg <= 1'b0;
		end else if (defaults_load) begin
			loopback_reg       <= 1'b0; // [R6]
			speed_lo_reg       <= strap_spd_lo_reg; // [R6] [R5]
			speed_hi_reg       <= strap_spd_hi_reg; // [R6] [R5]
			an_bit_reg         <= strap_an_reg; // [R6] [R5]
			duplex_bit_reg     <= strap_dup_reg; // [R6] [R5]
			power_down_reg     <= 1'b0; // [R6]
			isolate_reg        <= 1'b0; // [R6]
			collision_test_reg <= 1'b0; // [R6]
		end else if (bmc_wr && !sreset_busy) begin
			loopback_reg       <= wdata[`BMC_LOOP_BIT]; // [R9]
			speed_lo_reg       <= wdata[`BMC_SPD_LO_BIT];
			speed_hi_reg       <= wdata[`BMC_SPD_HI_BIT];
			an_bit_reg         <= wdata[`BMC_ANEN_BIT];
			duplex_bit_reg     <= wdata[`BMC_DUPLEX_BIT];
			power_down_reg     <= wdata[`BMC_PDOWN_BIT];
			isolate_reg        <= wdata[`BMC_ISOL_BIT];
			collision_test_reg <= wdata[`BMC_COLTEST_BIT];
		end
	end

	// ****************************************************************
	// Autonegotiation restart
	// ****************************************************************
	// Start of negotiation in the same cycle as a host write keeps the
	// bit set, so the request is not lost
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			restart_an_reg <= 1'b0;
		end else if (!strap_done_reg || defaults_load) begin
			restart_an_reg <= 1'b0; // [R6]
		end else if (bmc_wr && !sreset_busy &&
				wdata[`BMC_RESTART_BIT]) begin
			restart_an_reg <= 1'b1; // [R3]
		end else if (an_started) begin
			restart_an_reg <= 1'b0; // [R3]
		end
	end

	// ****************************************************************
	// Operating mode
	// ****************************************************************
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			speed_sel_reg      <= `SPD_10;
			full_duplex_reg    <= 1'b0;
			autoneg_enable_reg <= 1'b0;
		end else begin
			autoneg_enable_reg <= an_bit_reg;
			if (an_bit_reg) begin
				// Negotiated result wins over bits 6, 8 and 13
				speed_sel_reg   <= pick_speed(an_speed,
						speed_sel_reg); // [R11] [R12]
				full_duplex_reg <= an_full_duplex; // [R11]
			end else begin
				speed_sel_reg   <= pick_speed({speed_hi_reg,
						speed_lo_reg}, speed_sel_reg); // [R10] [R12]
				full_duplex_reg <= duplex_bit_reg; // [R11]
			end
		end
	end

	// ****************************************************************
	// Status latches
	// ****************************************************************
	status_latch #(
		.ACTIVE (1'b0)
	) u_link_latch (
		.ref_clk     (ref_clk),
		.arst_n      (arst_n),
		.clr         (defaults_load),
		.level       (link_up),
		.rd_ack      (stat_rd),
		.bit_val_reg (link_bit)
	);

	status_latch #(
		.ACTIVE (1'b1)
	) u_rfault_latch (
		.ref_clk     (ref_clk),
		.arst_n      (arst_n),
		.clr         (defaults_load),
		.level       (remote_fault),
		.rd_ack      (stat_rd),
		.bit_val_reg (rfault_bit)
	);

	status_latch #(
		.ACTIVE (1'b1)
	) u_jabber_latch (
		.ref_clk     (ref_clk),
		.arst_n      (arst_n),
		.clr         (defaults_load),
		.level       (jabber),
		.rd_ack      (stat_rd),
		.bit_val_reg (jabber_bit)
	);

	// ****************************************************************
	// Converter loopback
	// ****************************************************************
	converter_loop u_conv_loop (
		.ref_clk      (ref_clk),
		.arst_n       (arst_n),
		.loop_en      (loopback_reg),
		.tx_code      (tx_code),
		.adc_code     (adc_code),
		.dac_code_reg (dac_code_reg),
		.rx_code_reg  (rx_code_reg)
	);

	// ****************************************************************
	// Read path
	// ****************************************************************
	always @* begin
		bmc_view = {`DATA_W{1'b0}};
		bmc_view[`BMC_SRESET_BIT]  = sreset_busy; // [R7] [R3]
		bmc_view[`BMC_LOOP_BIT]    = loopback_reg;
		bmc_view[`BMC_SPD_LO_BIT]  = speed_lo_reg;
		bmc_view[`BMC_ANEN_BIT]    = an_bit_reg;
		bmc_view[`BMC_PDOWN_BIT]   = power_down_reg;
		bmc_view[`BMC_ISOL_BIT]    = isolate_reg;
		bmc_view[`BMC_RESTART_BIT] = restart_an_reg;
		bmc_view[`BMC_DUPLEX_BIT]  = duplex_bit_reg;
		bmc_view[`BMC_COLTEST_BIT] = collision_test_reg;
		bmc_view[`BMC_SPD_HI_BIT]  = speed_hi_reg;
	end

	always @* begin
		// Fixed ability bits ignore every write
		stat_view = `ST_PERM_VAL & `ST_PERM_MASK; // [R4]
		stat_view[`ST_ANDONE_BIT] = an_complete;
		stat_view[`ST_RFAULT_BIT] = rfault_bit; // [R1]
		stat_view[`ST_LINK_BIT]   = link_bit; // [R2]
		stat_view[`ST_JABBER_BIT] = jabber_bit; // [R1]
	end

	always @* begin
		case (addr)
			`BMC_ADDR: begin
				rd_mux = bmc_view;
			end
			`STAT_ADDR: begin
				rd_mux = stat_view;
			end
			default: begin
				rd_mux = {`DATA_W{1'b0}};
			end
		endcase
	end

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg <= {`DATA_W{1'b0}};
		end else if (rd_stb) begin
			rdata_reg <= rd_mux;
		end else begin
			rdata_reg <= {`DATA_W{1'b0}};
		end
	end

endmodule

/* hw/status_latch.v */
// Status bit that latches its active level until software reads it.
// Assumes the read acknowledge is a one-cycle pulse on the read strobe.
`timescale 1ns/100ps
module status_latch #(
	parameter ACTIVE = 1'b1
) (
	input  wire ref_clk,
	input  wire arst_n,
	input  wire clr,
	input  wire level,
	input  wire rd_ack,
	output reg  bit_val_reg
);
	reg  held_reg;
	wire hit;
	wire held_next;

	assign hit = (level == ACTIVE);
	// Event in the read cycle survives the clear
	assign held_next = hit | (held_reg & ~rd_ack); // [R1] [R2]

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			held_reg    <= 1'b0;
			bit_val_reg <= ~ACTIVE;
		end else if (clr) begin
			held_reg    <= 1'b0;
			bit_val_reg <= ~ACTIVE;
		end else begin
			held_reg    <= held_next;
			bit_val_reg <= held_next ? ACTIVE : level; // [R1] [R2]
		end
	end
endmodule

/* include/phy_bmc_consts.vh */
// Constants for the basic mode control register bank.
// Assumes a single 200 MHz core clock and an asynchronous active-low reset.
//
// Overview of operation
// R1 - Latch-high status bit sets on its event, holds until read, then tracks.
// R2 - Latch-low status bit clears on its event, holds zero until read.
// R3 - Self-clearing bit sets by event or host write, clears when done.
// R4 - Permanent bits always read their fixed value; writes do nothing.
// R5 - Strap bits take reset value from their pin level during reset; the code samples the pins on the first edge after release.
// R6 - Writing one to bit 15 resets all registers to defaults.
// R7 - Bit 15 reads one for about 1.2 ms, then clears itself.
// R8 - Reset ends once autonegotiation started or forced mode entered.
// R9 - Bit 14 loops transmit data to receive path at converters.
// R10 - With autonegotiation off, bits 6 and 13 set the speed.
// R11 - Autonegotiation on ignores bits 6, 8, 13; off lets them rule.
// R12 - Speed code 00=10M, 01=100M, 10=1000M; 11 selects nothing.
`ifndef PHY_BMC_CONSTS_VH
`define PHY_BMC_CONSTS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define ADDR_W          5
`define DATA_W          16
`define BMC_ADDR        5'h00
`define STAT_ADDR       5'h01

// ****************************************************************
// Basic mode control fields
// ****************************************************************
`define BMC_SRESET_BIT  15
`define BMC_LOOP_BIT    14
`define BMC_SPD_LO_BIT  13
`define BMC_ANEN_BIT    12
`define BMC_PDOWN_BIT   11
`define BMC_ISOL_BIT    10
`define BMC_RESTART_BIT 9
`define BMC_DUPLEX_BIT  8
`define BMC_COLTEST_BIT 7
`define BMC_SPD_HI_BIT  6

// ****************************************************************
// Status fields
// ****************************************************************
`define ST_ANDONE_BIT   5
`define ST_RFAULT_BIT   4
`define ST_LINK_BIT     2
`define ST_JABBER_BIT   1
`define ST_PERM_MASK    16'hff00
`define ST_PERM_VAL     16'h7900

// ****************************************************************
// Speed codes, high bit then low bit
// ****************************************************************
`define SPD_10          2'b00
`define SPD_100         2'b01
`define SPD_1000        2'b10
`define SPD_RSVD        2'b11

// ****************************************************************
// Converter path and timing
// ****************************************************************
`define CONV_W          8
`define CONV_IDLE       8'h00
`define CLK_PERIOD_NS   5
`define SRESET_TIME_NS  1200000
// 1.2 ms at 5 ns per cycle, sized to fit the counter
`define SRESET_CYCLES   18'd240000
`define SRESET_CNT_W    18

`endif

/* testbench/mac_side_core.sv */
// Core-side model: starts autonegotiation or forced mode on request.
// Assumes requests are registered levels from the control bank.
`timescale 1ns/100ps
module mac_side_core (
	input  wire ref_clk,
	input  wire arst_n,
	input  wire core_reset_reg,
	input  wire autoneg_enable_reg,
	input  wire restart_an_reg,
	input  wire slow,
	output reg  an_started,
	output reg  forced_mode_entered
);
reg [5:0] wait_reg;
// Slow answer keeps the bank waiting well past its timed phase
always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		wait_reg <= 6'h00;
		an_started <= 1'b0;
		forced_mode_entered <= 1'b0;
	end else begin
		an_started <= 1'b0;
		forced_mode_entered <= 1'b0;
		if (core_reset_reg || (restart_an_reg && wait_reg == 6'h00))
			wait_reg <= slow ? 6'h28 : 6'h01;
		else if (wait_reg != 6'h00) begin
			wait_reg <= wait_reg - 6'h01;
			if (wait_reg == 6'h01) begin
				an_started <= autoneg_enable_reg;
				forced_mode_entered <= !autoneg_enable_reg;
			end
		end
	end
end
endmodule

/* testbench/phy_bmc_properties.sv */
// Port-level assertions for the basic mode control register bank.
// Assumes it is bound into phy_basic_mode_control_bits.
`timescale 1ns/100ps
`include "phy_bmc_consts.vh"
module phy_bmc_properties #(
	parameter int SRESET_CYCLES = 20
) (
	input wire               ref_clk,
	input wire               arst_n,
	input wire [`ADDR_W-1:0] addr,
	input wire               rd_stb,
	input wire [`DATA_W-1:0] rdata_reg,
	input wire [1:0]         an_speed,
	input wire               link_up,
	input wire               jabber,
	input wire [`CONV_W-1:0] tx_code,
	input wire [`CONV_W-1:0] adc_code,
	input wire [`CONV_W-1:0] dac_code_reg,
	input wire [`CONV_W-1:0] rx_code_reg,
	input wire               core_reset_reg,
	input wire               loopback_reg,
	input wire [1:0]         speed_sel_reg,
	input wire               autoneg_enable_reg,
	input wire               restart_an_reg,
	input wire               power_down_reg,
	input wire               isolate_reg,
	input wire               collision_test_reg
);
default clocking @(posedge ref_clk); endclocking
default disable iff (!arst_n);
// ****
// Helper logic
// ****
wire       rd_stat = rd_stb && addr == `STAT_ADDR;
reg [17:0] hi_cnt_reg;
reg        jab_seen_reg;
reg        link_lost_reg;
// Reference for the latched bits; an event in the read cycle survives
always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		jab_seen_reg  <= 1'b0;
		link_lost_reg <= 1'b0;
	end else if (core_reset_reg) begin
		jab_seen_reg  <= 1'b0;
		link_lost_reg <= 1'b0;
	end else if (rd_stat) begin
		jab_seen_reg  <= jabber;
		link_lost_reg <= !link_up;
	end else begin
		jab_seen_reg  <= jab_seen_reg | jabber;
		link_lost_reg <= link_lost_reg | !link_up;
	end
end
// Counts sampled high cycles of the timed reset phase
always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n)
		hi_cnt_reg <= 18'h00000;
	else if (core_reset_reg)
		hi_cnt_reg <= hi_cnt_reg + 18'h00001;
	else
		hi_cnt_reg <= 18'h00000;
end
// ****
// Properties
// ****
property p_perm;
	rd_stat |=> (rdata_reg & `ST_PERM_MASK) == `ST_PERM_VAL;
endproperty
a_perm: assert property (p_perm) else $error("permanent bits wrong");
property p_lh;
	rd_stat && !core_reset_reg && jab_seen_reg |=> rdata_reg[`ST_JABBER_BIT];
endproperty
a_lh: assert property (p_lh) else $error("latch high lost");
property p_ll;
	rd_stat && !core_reset_reg && link_lost_reg |=> !rdata_reg[`ST_LINK_BIT];
endproperty
a_ll: assert property (p_ll) else $error("latch low lost");
property p_held;
	core_reset_reg |-> !(loopback_reg || power_down_reg || isolate_reg
		|| restart_an_reg || collision_test_reg);
endproperty
a_held: assert property (p_held) else $error("fields not default");
property p_len;
	$fell(core_reset_reg) |-> hi_cnt_reg == SRESET_CYCLES;
endproperty
a_len: assert property (p_len) else $error("reset phase length");
property p_loop;
	loopback_reg |=> rx_code_reg == $past(tx_code)
		&& dac_code_reg == `CONV_IDLE;
endproperty
a_loop: assert property (p_loop) else $error("loopback path wrong");
property p_norm;
	!loopback_reg |=> rx_code_reg == $past(adc_code)
		&& dac_code_reg == $past(tx_code);
endproperty
a_norm: assert property (p_norm) else $error("normal path wrong");
property p_spd_an;
	(autoneg_enable_reg && $stable(an_speed) && an_speed != `SPD_RSVD)[*2]
		|-> speed_sel_reg == an_speed;
endproperty
a_spd_an: assert property (p_spd_an) else $error("speed not negotiated");
property p_rsvd;
	speed_sel_reg != `SPD_RSVD;
endproperty
a_rsvd: assert property (p_rsvd) else $error("reserved speed used");
c_reset: cover property ($fell(core_reset_reg));
c_loop: cover property (loopback_reg);
c_lh: cover property (rd_stat && jab_seen_reg);
endmodule

bind phy_basic_mode_control_bits phy_bmc_properties #(
	.SRESET_CYCLES(SRESET_CYCLES)
) chk (.*);

/* testbench/test_phy_basic_mode_control_bits.sv */
// Self-checking bench for the basic mode control register bank.
// Assumes the core-side model answers soft reset and restart.
`timescale 1ns/100ps
`include "phy_bmc_consts.vh"
module test_phy_basic_mode_control_bits;
reg        ref_clk, arst_n, wr_stb, rd_stb, slow;
reg [4:0]  addr;
reg [15:0] wdata, d;
reg        strap_autoneg_enable, strap_speed_lo, strap_speed_hi;
reg        strap_full_duplex, an_complete, an_full_duplex;
reg        link_up, remote_fault, jabber;
reg [1:0]  an_speed;
reg [7:0]  tx_code, adc_code;
wire [15:0] rdata_reg;
wire [7:0]  dac_code_reg, rx_code_reg;
wire [1:0]  speed_sel_reg;
wire        an_started, forced_mode_entered, core_reset_reg, loopback_reg;
wire        full_duplex_reg, autoneg_enable_reg, restart_an_reg;
wire        power_down_reg, isolate_reg, collision_test_reg;
int         n_fail, samples_checked, cyc, i, k;

phy_basic_mode_control_bits #(.SRESET_CYCLES(18'd20)) uut (.*);
mac_side_core core (.*);

initial begin
	ref_clk = 1'b0;
	forever #2.5 ref_clk = ~ref_clk;
end
// ****
// Tasks
// ****
task tick(input int n);
	repeat (n) @(posedge ref_clk);
	#1;
endtask
task wr(input [4:0] a, input [15:0] v);
	@(posedge ref_clk);
	addr <= a;
	wdata <= v;
	wr_stb <= 1'b1;
	@(posedge ref_clk);
	wr_stb <= 1'b0;
endtask
task rd(input [4:0] a, output [15:0] v);
	@(posedge ref_clk);
	addr <= a;
	rd_stb <= 1'b1;
	@(posedge ref_clk);
	rd_stb <= 1'b0;
	#1 v = rdata_reg;
endtask
task cmp(input [15:0] got, input [15:0] exp);
	samples_checked++;
	if (got !== exp) begin
		n_fail++;
		$display("FAIL %0t got %h expected %h", $time, got, exp);
	end
endtask
task endt(input int n);
	$display("test %0d done", n);
endtask
task report_and_stop;
	$display("checks %0d mismatches %0d", samples_checked, n_fail);
	if (n_fail == 0 && samples_checked > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask
// Hang guard, well above the roughly 130 cycles needed
always @(posedge ref_clk) begin
	cyc <= cyc + 1;
	if (cyc == 20000) begin
		n_fail++;
		report_and_stop;
	end
end
// ****
// Sequence
// ****
initial begin
	{arst_n, wr_stb, rd_stb, slow, addr, wdata} = 0;
	{strap_autoneg_enable, strap_speed_lo} = 2'b01;
	{strap_speed_hi, strap_full_duplex} = 2'b01;
	{an_complete, an_full_duplex, link_up} = 3'b101;
	{remote_fault, jabber} = 2'b00;
	an_speed = 2'b10;
	tx_code = 8'h00;
	adc_code = 8'h00;
	repeat (10) @(posedge ref_clk);
	arst_n <= 1'b1;
	tick(2);
	rd(`BMC_ADDR, d); cmp(d, 16'h2100);
	cmp(16'(speed_sel_reg), 16'h1);
	cmp(16'(full_duplex_reg), 16'h1);
	endt(1);
	for (i = 0; i < 4; i++) begin
		wr(`BMC_ADDR, (16'(i[0]) << 13) | (16'(i[1]) << 6));
		tick(2);
		cmp(16'(speed_sel_reg), i == 3 ? 16'h2 : 16'(i));
	end
	wr(`BMC_ADDR, 16'h3040); tick(2);
	cmp(16'(speed_sel_reg), 16'h2);
	@(posedge ref_clk);
	an_speed <= 2'b01;
	tick(2);
	cmp(16'(speed_sel_reg), 16'h1);
	cmp(16'(full_duplex_reg), 16'h0);
	endt(2);
	@(posedge ref_clk);
	tx_code <= 8'h5a;
	adc_code <= 8'ha5;
	wr(`BMC_ADDR, 16'h4000); tick(3);
	cmp(16'(rx_code_reg), 16'h5a);
	cmp(16'(dac_code_reg), 16'h0);
	wr(`BMC_ADDR, 16'h0); tick(3);
	cmp(16'(rx_code_reg), 16'ha5);
	cmp(16'(dac_code_reg), 16'h5a);
	endt(3);
	@(posedge ref_clk);
	{jabber, remote_fault, link_up} <= 3'b110;
	@(posedge ref_clk);
	{jabber, remote_fault, link_up} <= 3'b001;
	rd(`STAT_ADDR, d); cmp(d, 16'h7932);
	rd(`STAT_ADDR, d); cmp(d, 16'h7924);
	wr(`STAT_ADDR, 16'h0);
	rd(`STAT_ADDR, d); cmp(d, 16'h7924);
	rd(5'h1f, d); cmp(d, 16'h0);
	endt(4);
	wr(`BMC_ADDR, 16'h1200); tick(1);
	cmp(16'(restart_an_reg), 16'h1);
	k = 0;
	while (restart_an_reg !== 1'b0 && k < 50) begin
		tick(1);
		k++;
	end
	cmp(16'(restart_an_reg), 16'h0);
	endt(5);
	wr(`BMC_ADDR, 16'h4c80);
	tick(1);
	cmp(16'({power_down_reg, isolate_reg, collision_test_reg}), 16'h7);
	@(posedge ref_clk);
	slow <= 1'b1;
	// Set bits beside bit 15 must not survive the reset start
	wr(`BMC_ADDR, 16'hc000);
	rd(`BMC_ADDR, d); cmp(d, 16'ha100);
	// Ignored while busy, so loopback must stay off afterwards
	wr(`BMC_ADDR, 16'h4000);
	k = 0;
	while (core_reset_reg !== 1'b0 && k < 50) begin
		tick(1);
		k++;
	end
	rd(`BMC_ADDR, d); cmp(16'(d[15]), 16'h1);
	k = 0;
	do begin
		rd(`BMC_ADDR, d);
		k++;
	end while (d[15] !== 1'b0 && k < 60);
	cmp(d, 16'h2100);
	cmp(16'({loopback_reg, power_down_reg, isolate_reg,
		collision_test_reg}), 16'h0);
	endt(6);
	report_and_stop;
end
endmodule
